//--- src/vk_keyer.sv
// Purpose: Video keyer: key control generation, fill treatment, compositing.
// Assumes: Pixel stream synchronous to sys_clk_in, qualified by pix_valid_in.
// Notes: Output sample is the input sample four valid samples earlier.
//
// Design decisions made here: the Avalon-MM slave port and the address map.
`timescale 1ns/10ps
module vk_keyer (
  input wire logic sys_clk_in, // 100 MHz pixel clock
  input wire logic sys_rst_in, // Asynchronous reset, active high
  input wire logic [3:0] avs_address_in, // Avalon word address
  input wire logic avs_read_in, // Avalon read
  input wire logic avs_write_in, // Avalon write
  input wire logic [31:0] avs_writedata_in, // Avalon write data
  input wire logic [3:0] avs_byteenable_in, // Avalon byte enables
  output logic [31:0] avs_readdata_out, // Avalon read data
  output logic avs_waitrequest_out, // Avalon wait request
  input wire logic field_start_in, // Field start pulse
  input wire logic pix_valid_in, // Input pixel valid
  input wire logic [7:0] key_cut_in, // Key cut video
  input wire logic [7:0] split_cut_in, // Alternate key cut for split key
  input wire logic [7:0] pattern_in, // Wipe pattern level
  input wire logic [7:0] fill_y_in, // Fill luma
  input wire logic [7:0] fill_cb_in, // Fill Cb
  input wire logic [7:0] fill_cr_in, // Fill Cr
  input wire logic [7:0] bg_y_in, // Background luma
  input wire logic [7:0] bg_cb_in, // Background Cb
  input wire logic [7:0] bg_cr_in, // Background Cr
  output logic pix_valid_out, // Output pixel valid
  output logic [7:0] out_y_out, // Composite luma
  output logic [7:0] out_cb_out, // Composite Cb
  output logic [7:0] out_cr_out, // Composite Cr
  output logic [7:0] key_out // Final key control
);
  vk_pkg::vk_state_t s;
  vk_pkg::vk_state_t n;

  function automatic logic signed [17:0] sx(input logic [7:0] v);
    sx = $signed({10'h000, v});
  endfunction : sx

  function automatic logic [7:0] sat8(input logic signed [17:0] v);
    if (v < 18'sh00000) sat8 = 8'h00;
    else if (v > 18'sh000FF) sat8 = 8'hFF;
    else sat8 = v[7:0];
  endfunction : sat8

  function automatic logic [7:0] mul8(input logic [7:0] a, input logic [7:0] b);
    logic [15:0] p;
    logic [15:0] r;
    p = a * b;
    r = p + 16'h0080;
    r = r + {8'h00, r[15:8]};
    mul8 = r[15:8];
  endfunction : mul8

  // Chroma offset from 0x80 scaled by k, result is a signed offset
  function automatic logic signed [17:0] mulc(input logic [7:0] c, input logic [7:0] k);
    logic signed [17:0] p;
    p = (sx(c) - 18'sh00080) * sx(k);
    mulc = (p + 18'sh00080) >>> 8;
  endfunction : mulc

  function automatic logic [7:0] absd(input logic [7:0] a, input logic [7:0] b);
    absd = (a > b) ? a - b : b - a;
  endfunction : absd

  function automatic logic [7:0] ramp(input logic [7:0] d, input logic [7:0] w);
    if (w == 8'h00) ramp = 8'hFF;
    else ramp = sat8((sx(d) * 18'sh000FF) / sx(w));
  endfunction : ramp

  // Clip sets the midpoint, gain percent sets the transition width
  function automatic logic [7:0] cg(input logic [7:0] r, input logic [7:0] c,
                                     input logic [7:0] g);
    logic [15:0] w;
    logic signed [17:0] d;
    logic signed [17:0] q;
    w = ({8'h00, g} * 16'h00FF) / {8'h00, vk_pkg::GAIN_UNITY_PCT};
    d = (sx(r) - sx(c)) * 18'sh000FF;
    q = 18'sh00000;
    if (w == 16'h0000) begin
      cg = (r >= c) ? 8'hFF : 8'h00;
    end else begin
      q = d / $signed({2'b00, w});
      cg = sat8(q + 18'sh00080);
    end
  endfunction : cg

  // Smoothstep, keeps 0, mid and full fixed
  function automatic logic [7:0] sshape(input logic [7:0] x);
    logic [15:0] x2;
    logic [15:0] x3;
    x2 = x * x;
    x3 = x2[15:8] * x;
    sshape = sat8(sx(x2[15:8]) * 18'sh00003 - sx(x3[15:8]) * 18'sh00002);
  endfunction : sshape

  function automatic logic [7:0] trim(input logic [7:0] b, input logic [7:0] t);
    logic signed [17:0] tv;
    tv = 18'($signed(t));
    if (tv > sx(vk_pkg::TRIM_MAX)) tv = sx(vk_pkg::TRIM_MAX);
    if (tv < -sx(vk_pkg::TRIM_MAX)) tv = -sx(vk_pkg::TRIM_MAX);
    trim = sat8(sx(b) + tv);
  endfunction : trim

  wire logic [31:0] ctl = s.act[vk_pkg::R_CTRL];
  wire logic [2:0] mode = ctl[vk_pkg::F_MODE +: 3];
  wire logic adj = ctl[vk_pkg::F_ADJ];
  wire logic inv = ctl[vk_pkg::F_INV];
  wire logic show = ctl[vk_pkg::F_SHOW];
  wire logic core = ctl[vk_pkg::F_CORE];
  wire logic resh = ctl[vk_pkg::F_RESH];
  wire logic [7:0] clp = s.act[vk_pkg::R_CLIP][vk_pkg::F_B0 +: 8];
  wire logic [7:0] gn = s.act[vk_pkg::R_CLIP][vk_pkg::F_B1 +: 8];
  wire logic [7:0] tclp = s.act[vk_pkg::R_TRIM][vk_pkg::F_B0 +: 8];
  wire logic [7:0] tgn = s.act[vk_pkg::R_TRIM][vk_pkg::F_B1 +: 8];
  wire logic [7:0] op = s.act[vk_pkg::R_SHAPE][vk_pkg::F_B0 +: 8];
  wire logic [2:0] pos = s.act[vk_pkg::R_SHAPE][vk_pkg::F_POS +: 3];
  wire logic [1:0] size = s.act[vk_pkg::R_SHAPE][vk_pkg::F_SIZE +: 2];
  wire logic [7:0] hcb = s.act[vk_pkg::R_HUE][vk_pkg::F_B0 +: 8];
  wire logic [7:0] hcr = s.act[vk_pkg::R_HUE][vk_pkg::F_B1 +: 8];
  wire logic [7:0] pw = s.act[vk_pkg::R_HUE][vk_pkg::F_B2 +: 8];
  wire logic [7:0] sw = s.act[vk_pkg::R_HUE][vk_pkg::F_B3 +: 8];
  wire logic [7:0] sy = s.act[vk_pkg::R_SUPP][vk_pkg::F_B0 +: 8];
  wire logic [7:0] sc = s.act[vk_pkg::R_SUPP][vk_pkg::F_B1 +: 8];
  wire logic [7:0] fl = s.act[vk_pkg::R_SUPP][vk_pkg::F_B2 +: 8];
  wire logic [7:0] soff = s.act[vk_pkg::R_SHAD][vk_pkg::F_B0 +: 8];
  wire logic [7:0] srng = s.act[vk_pkg::R_SHAD][vk_pkg::F_B1 +: 8];
  wire logic [7:0] sden = s.act[vk_pkg::R_SHAD][vk_pkg::F_B2 +: 8];

  always_comb begin
    logic [7:0] nar;
    logic [7:0] cs;
    logic [7:0] c;
    logic [7:0] g;
    logic [7:0] kc;
    logic [7:0] ps;
    logic [7:0] ss;
    logic [7:0] y;
    logic [7:0] cb;
    logic [7:0] cr;
    logic [7:0] k;
    logic [7:0] by;
    logic [3:0] ti;
    nar = 8'h00;
    cs = 8'h00;
    c = 8'h00;
    g = 8'h00;
    kc = 8'h00;
    ps = 8'h00;
    ss = 8'h00;
    y = 8'h00;
    cb = 8'h00;
    cr = 8'h00;
    k = 8'h00;
    by = 8'h00;
    ti = 4'h0;
    n = s;
    // Avalon slave: one wait cycle, then the access completes
    case (s.bus)
      vk_pkg::VK_BUS_IDLE: begin
        if (avs_read_in || avs_write_in) begin
          n.bus = vk_pkg::VK_BUS_ACK;
          if (avs_address_in < vk_pkg::NREG) n.rdata = s.sh[avs_address_in[2:0]];
          else if (avs_address_in == vk_pkg::R_STAT) n.rdata = {s.ko, 8'h00, s.fields};
          else n.rdata = 32'h0000_0000;
        end
      end
      vk_pkg::VK_BUS_ACK: begin
        n.bus = vk_pkg::VK_BUS_IDLE;
        if (avs_write_in && avs_address_in < vk_pkg::NREG) begin
          for (int b = 0; b < 4; b++) begin
            if (avs_byteenable_in[b]) begin
              n.sh[avs_address_in[2:0]][b * 8 +: 8] = avs_writedata_in[b * 8 +: 8];
            end
          end
        end
      end
      default: n.bus = vk_pkg::VK_BUS_IDLE;
    endcase
    n.wreq = (n.bus != vk_pkg::VK_BUS_ACK);
    if (field_start_in) begin
      n.act = s.sh;
      n.fields = s.fields + 16'h0001;
    end
    // Input delay lines
    if (pix_valid_in) begin
      if (mode == vk_pkg::M_SPLIT) cs = split_cut_in;
      else if (mode == vk_pkg::M_SELF) cs = fill_y_in;
      else cs = key_cut_in;
      n.cut = {s.cut[9:0], cs};
      n.fil = {s.fil[2:0], fill_y_in, fill_cb_in, fill_cr_in};
      n.bg = {s.bg[2:0], bg_y_in, bg_cb_in, bg_cr_in};
      n.pat = {s.pat[2:0], pattern_in};
    end
    // Stage 1: positioning, narrowing, raw key source
    n.v1 = pix_valid_in;
    nar = s.cut[pos];
    for (int i = 1; i < 4; i++) begin
      ti = 4'(pos) + 4'(i);
      if (2'(i) <= size && s.cut[ti] < nar) nar = s.cut[ti];
    end
    case (mode)
      vk_pkg::M_PATTERN: n.raw1 = s.pat[3];
      vk_pkg::M_CHROMA: n.raw1 = sat8(sx(absd(s.fil[3][15:8], hcb))
                                      + sx(absd(s.fil[3][7:0], hcr)));
      default: n.raw1 = nar;
    endcase
    n.f1 = s.fil[3];
    n.b1 = s.bg[3];
    // Stage 2: key control and fill treatment
    n.v2 = s.v1;
    if (mode == vk_pkg::M_LINEAR && !adj) begin
      c = vk_pkg::FIX_CLIP;
      g = vk_pkg::GAIN_UNITY_PCT;
    end else if (mode == vk_pkg::M_LINEAR) begin
      c = trim(vk_pkg::FIX_CLIP, tclp);
      g = trim(vk_pkg::GAIN_UNITY_PCT, tgn);
    end else begin
      c = clp;
      g = gn;
    end
    kc = (mode == vk_pkg::M_PATTERN) ? s.raw1 : cg(s.raw1, c, g);
    if (mode == vk_pkg::M_SELF) kc = sshape(kc);
    if (inv) kc = ~kc;
    n.k2 = mul8(kc, op);
    y = s.f1[23:16];
    cb = s.f1[15:8];
    cr = s.f1[7:0];
    n.shd2 = 8'h00;
    if (mode == vk_pkg::M_CHROMA) begin
      cb = sat8(sx(cb) - mulc(hcb, fl));
      cr = sat8(sx(cr) - mulc(hcr, fl));
      ps = ramp(s.raw1, pw);
      ss = ramp(s.raw1, sw);
      cb = sat8(18'sh00080 + mulc(cb, ss));
      cr = sat8(18'sh00080 + mulc(cr, ss));
      n.shd2 = mul8(mul8(ramp(sat8(sx(soff) - sx(y)), srng), sden), ~n.k2);
      y = sat8(sx(mul8(y, ps)) + sx(mul8(sy, ~ps)));
      cb = sat8(18'sh00080 + mulc(cb, ps) + mulc(sc, ~ps));
      cr = sat8(18'sh00080 + mulc(cr, ps) + mulc(sc, ~ps));
    end
    n.f2 = {y, cb, cr};
    n.b2 = s.b1;
    case (mode)
      vk_pkg::M_LINEAR: n.shp2 = ctl[vk_pkg::F_SHP];
      vk_pkg::M_CHROMA: n.shp2 = !resh;
      vk_pkg::M_SPLIT: n.shp2 = ctl[vk_pkg::F_OVR];
      default: n.shp2 = 1'b0;
    endcase
    // Stage 3: shaping, coring, composite
    n.vo = s.v2;
    k = s.k2;
    y = s.f2[23:16];
    cb = s.f2[15:8];
    cr = s.f2[7:0];
    if (!s.shp2) begin
      y = mul8(y, k);
      cb = sat8(18'sh00080 + mulc(cb, k));
      cr = sat8(18'sh00080 + mulc(cr, k));
    end
    if (core && k == 8'h00) begin
      y = vk_pkg::BLACK_Y;
      cb = vk_pkg::CHROMA_ZERO;
      cr = vk_pkg::CHROMA_ZERO;
    end
    by = mul8(mul8(s.b2[23:16], ~s.shd2), ~k);
    n.po = {sat8(sx(y) + sx(by)),
            sat8(sx(cb) + mulc(s.b2[15:8], ~k)),
            sat8(sx(cr) + mulc(s.b2[7:0], ~k))};
    if (show) n.po = {k, vk_pkg::CHROMA_ZERO, vk_pkg::CHROMA_ZERO};
    n.ko = k;
  end

  always_ff @(posedge sys_clk_in or posedge sys_rst_in) begin
    if (sys_rst_in) begin
      s <= '0;
      s.bus <= vk_pkg::VK_BUS_IDLE;
      s.wreq <= 1'b1;
      s.sh <= vk_pkg::RST_REGS;
      s.act <= vk_pkg::RST_REGS;
    end else begin
      s <= n;
    end
  end

  assign avs_readdata_out = s.rdata;
  assign avs_waitrequest_out = s.wreq;
  assign pix_valid_out = s.vo;
  assign out_y_out = s.po[23:16];
  assign out_cb_out = s.po[15:8];
  assign out_cr_out = s.po[7:0];
  assign key_out = s.ko;

  default clocking cb_main @(posedge sys_clk_in);
  endclocking
  default disable iff (sys_rst_in);

  sequence bus_req;
    (avs_read_in || avs_write_in) && s.wreq && s.bus == vk_pkg::VK_BUS_IDLE;
  endsequence
  sequence bus_done;
    !avs_waitrequest_out ##1 avs_waitrequest_out;
  endsequence

  chk_bus_answer: assert property (bus_req |=> bus_done)
    else $error("bus request not answered after one wait cycle");
  chk_bus_write: assert property (avs_write_in && !s.wreq && avs_byteenable_in == 4'hF
      && avs_address_in == vk_pkg::R_CLIP |=> s.sh[vk_pkg::R_CLIP] == $past(avs_writedata_in))
    else $error("register write lost");
  chk_field_take: assert property (field_start_in |=> s.act == $past(s.sh))
    else $error("parameters not taken at field start");
  chk_field_hold: assert property (!field_start_in |=> s.act == $past(s.act))
    else $error("parameters changed within a field");
  chk_opacity_zero: assert property (s.v1 && op == 8'h00 && !field_start_in |=> s.k2 == 8'h00)
    else $error("zero opacity left key visible");
  chk_invert_pattern: assert property (s.v1 && mode == vk_pkg::M_PATTERN && inv
      && op == 8'hFF && !field_start_in |=> s.k2 == ~$past(s.raw1))
    else $error("inverted pattern key wrong");
  chk_fixed_unity: assert property (s.v1 && mode == vk_pkg::M_LINEAR && !adj && !inv
      && op == 8'hFF && !field_start_in |=> s.k2 == $past(s.raw1))
    else $error("fixed linear key not unity");
  chk_hard_edge: assert property (s.v1 && mode == vk_pkg::M_SPLIT && gn == 8'h00 && !inv
      && op == 8'hFF && !field_start_in |=> s.k2 == 8'h00 || s.k2 == 8'hFF)
    else $error("zero gain key not hard");
  chk_coring_black: assert property (s.v2 && core && s.k2 == 8'h00 && !show
      && mode != vk_pkg::M_CHROMA && !field_start_in |=> out_y_out == $past(s.b2[23:16]))
    else $error("coring left fill outside key");
  chk_show_mono: assert property (s.v2 && show && !field_start_in |=>
      out_y_out == $past(s.k2) && out_cb_out == vk_pkg::CHROMA_ZERO)
    else $error("show key not monochrome key");
  chk_valid_delay: assert property (pix_valid_in |-> ##3 pix_valid_out)
    else $error("output valid not three cycles after input valid");
  chk_key_output: assert property (s.v2 |=> key_out == $past(s.k2))
    else $error("key output not the final key");
  chk_split_source: assert property (pix_valid_in && mode == vk_pkg::M_SPLIT
      |=> s.cut[0] == $past(split_cut_in))
    else $error("split key did not take the alternate cut");
  chk_self_source: assert property (pix_valid_in && mode == vk_pkg::M_SELF
      |=> s.cut[0] == $past(fill_y_in))
    else $error("self key did not take fill luma as cut");
  chk_pattern_plain: assert property (s.v1 && mode == vk_pkg::M_PATTERN && !inv
      && op == 8'hFF && !field_start_in |=> s.k2 == $past(s.raw1))
    else $error("pattern key altered by clip or gain");
  chk_status_read: assert property (s.bus == vk_pkg::VK_BUS_IDLE && avs_read_in
      && avs_address_in == vk_pkg::R_STAT |=> avs_readdata_out[15:0] == $past(s.fields))
    else $error("status read lost the field count");
endmodule : vk_keyer

//--- src/vk_pkg.sv
// Purpose: Shared constants and state types for the video keyer.
// Assumes: 8-bit full-range Y, chroma offset by 0x80, one pixel clock.
// Notes: Register words are 32 bits at word addresses on Avalon-MM.
package vk_pkg;
  // Register word addresses
  localparam logic [3:0] R_CTRL = 4'h0;
  localparam logic [3:0] R_CLIP = 4'h1;
  localparam logic [3:0] R_TRIM = 4'h2;
  localparam logic [3:0] R_SHAPE = 4'h3;
  localparam logic [3:0] R_HUE = 4'h4;
  localparam logic [3:0] R_SUPP = 4'h5;
  localparam logic [3:0] R_SHAD = 4'h6;
  localparam logic [3:0] R_STAT = 4'h7;
  localparam logic [3:0] NREG = 4'h7;
  // Control word bit positions
  localparam int F_MODE = 0;
  localparam int F_ADJ = 3;
  localparam int F_INV = 4;
  localparam int F_SHOW = 5;
  localparam int F_CORE = 6;
  localparam int F_RESH = 7;
  localparam int F_SHP = 8;
  localparam int F_OVR = 9;
  // Byte lanes of the parameter words, key position and size fields
  localparam int F_B0 = 0;
  localparam int F_B1 = 8;
  localparam int F_B2 = 16;
  localparam int F_B3 = 24;
  localparam int F_POS = 8;
  localparam int F_SIZE = 12;
  // Key modes
  localparam logic [2:0] M_LINEAR = 3'h0;
  localparam logic [2:0] M_SELF = 3'h1;
  localparam logic [2:0] M_CHROMA = 3'h2;
  localparam logic [2:0] M_PATTERN = 3'h3;
  localparam logic [2:0] M_SPLIT = 3'h4;
  // Fixed linear key, trim limit, video levels
  localparam logic [7:0] FIX_CLIP = 8'h80;
  localparam logic [7:0] GAIN_UNITY_PCT = 8'h64;
  localparam logic [7:0] TRIM_MAX = 8'h20;
  localparam logic [7:0] BLACK_Y = 8'h00;
  localparam logic [7:0] CHROMA_ZERO = 8'h80;
  localparam logic [7:0] FULL = 8'hFF;
  // Reset values
  localparam logic [31:0] RST_CTRL = 32'h0000_0000;
  localparam logic [31:0] RST_CLIP = 32'h0000_6480;
  localparam logic [31:0] RST_TRIM = 32'h0000_0000;
  localparam logic [31:0] RST_SHAPE = 32'h0000_03FF;
  localparam logic [31:0] RST_HUE = 32'h2060_4040;
  localparam logic [31:0] RST_SUPP = 32'h0010_8000;
  localparam logic [31:0] RST_SHAD = 32'h0000_4060;
  localparam logic [6:0][31:0] RST_REGS = {RST_SHAD, RST_SUPP, RST_HUE, RST_SHAPE,
                                           RST_TRIM, RST_CLIP, RST_CTRL};
  typedef enum logic {VK_BUS_IDLE, VK_BUS_ACK} vk_bus_t;
  typedef struct packed {
    vk_bus_t bus;
    logic wreq;
    logic [31:0] rdata;
    logic [6:0][31:0] sh;
    logic [6:0][31:0] act;
    logic [15:0] fields;
    logic [10:0][7:0] cut;
    logic [3:0][23:0] fil;
    logic [3:0][23:0] bg;
    logic [3:0][7:0] pat;
    logic v1;
    logic [7:0] raw1;
    logic [23:0] f1;
    logic [23:0] b1;
    logic v2;
    logic [7:0] k2;
    logic [7:0] shd2;
    logic shp2;
    logic [23:0] f2;
    logic [23:0] b2;
    logic vo;
    logic [23:0] po;
    logic [7:0] ko;
  } vk_state_t;
endpackage : vk_pkg

//--- testbench/vk_src_model.sv
// Purpose: Video source model feeding the keyer pixel inputs.
// Assumes: Levels change just after rising edges; random values from an LFSR.
// Notes: Idle lines toggle so a stale sample is never mistaken for data.
`timescale 1ns/10ps
module vk_src_model (
  input wire logic sys_clk_in, // Pixel clock
  input wire logic en_in, // Send a sample next cycle
  input wire logic [7:0] cut_mask_in, // Mask on the key cut level
  output logic valid_out, // Sample valid
  output logic [8:0][7:0] px_out // Cut, split, pattern, fill YCbCr, bg YCbCr
);
  logic [31:0] lfsr_q = 32'h0000_6A8D;
  function automatic logic [31:0] lfsr_step(input logic [31:0] x);
    return x[0] ? ((x >> 1) ^ 32'hA300_0000) : (x >> 1);
  endfunction : lfsr_step
  initial begin
    valid_out = 1'b0;
    px_out = '0;
  end
  always @(posedge sys_clk_in) begin : gen
    logic [31:0] x;
    x = lfsr_q;
    for (int i = 0; i < 9; i++) begin
      x = lfsr_step(x);
      px_out[i] <= en_in ? (x[7:0] & ((i == 0) ? cut_mask_in : 8'hFF)) : ~px_out[i];
    end
    lfsr_q <= x;
    valid_out <= en_in;
  end
endmodule : vk_src_model

//--- testbench/vk_keyer_tb_top.sv
// Purpose: Self-checking bench for the video keyer.
// Assumes: Output of a sample appears four valid samples later.
// Notes: The last four samples of a burst are not checked; they leave later.
`timescale 1ns/10ps
module vk_keyer_tb_top;
  typedef struct packed {logic care; logic show; logic [7:0] y; logic [7:0] k;} vk_note_t;
  logic sys_clk_in = 1'b0;
  logic sys_rst_in = 1'b1;
  logic [3:0] adr = 4'h0;
  logic rd = 1'b0;
  logic wr = 1'b0;
  logic [31:0] wdat = 32'h0000_0000;
  logic [3:0] be = 4'hF;
  logic [31:0] rdat;
  logic wait_rq;
  logic fs = 1'b0;
  logic en = 1'b0;
  logic [7:0] mask = 8'hFF;
  logic pv;
  logic [8:0][7:0] px;
  logic vo;
  logic [7:0] oy, ocb, ocr, ko;
  int fails = 0;
  int cmp_count = 0;
  int idx = 0;
  int e_gain = 100;
  logic [9:0] e_ctrl = 10'h000;
  logic [7:0] e_op = 8'hFF;
  vk_note_t notes[$];
  vk_note_t mon_n;
  always #5 sys_clk_in = ~sys_clk_in;
  vk_keyer dut (.sys_clk_in(sys_clk_in), .sys_rst_in(sys_rst_in), .avs_address_in(adr),
    .avs_read_in(rd), .avs_write_in(wr), .avs_writedata_in(wdat), .avs_byteenable_in(be),
    .avs_readdata_out(rdat), .avs_waitrequest_out(wait_rq), .field_start_in(fs),
    .pix_valid_in(pv), .key_cut_in(px[0]), .split_cut_in(px[1]), .pattern_in(px[2]),
    .fill_y_in(px[3]), .fill_cb_in(px[4]), .fill_cr_in(px[5]), .bg_y_in(px[6]),
    .bg_cb_in(px[7]), .bg_cr_in(px[8]), .pix_valid_out(vo), .out_y_out(oy),
    .out_cb_out(ocb), .out_cr_out(ocr), .key_out(ko));
  vk_src_model src (.sys_clk_in(sys_clk_in), .en_in(en), .cut_mask_in(mask),
    .valid_out(pv), .px_out(px));
  task automatic check(input logic [31:0] got, input logic [31:0] exp, input string what);
    cmp_count++;
    if (got !== exp) begin
      fails++;
      $display("ERROR %0t %s got %h exp %h", $time, what, got, exp);
    end
  endtask : check
  task automatic end_sim;
    $display("comparisons %0d mismatches %0d", cmp_count, fails);
    if (fails == 0 && cmp_count > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask : end_sim
  // Expected key and luma of one sample under the active settings
  function automatic vk_note_t note_of(input logic [8:0][7:0] p, input logic care);
    int raw, k, y, bgt;
    raw = (e_ctrl[2:0] == vk_pkg::M_PATTERN) ? p[2]
        : (e_ctrl[2:0] == vk_pkg::M_SPLIT) ? p[1] : p[0];
    k = raw;
    if (e_ctrl[2:0] != vk_pkg::M_PATTERN) begin
      if (e_gain == 0) k = (raw >= 128) ? 255 : 0;
      else k = (raw - 128) * 255 / (e_gain * 255 / 100) + 128;
    end
    k = (k < 0) ? 0 : (k > 255) ? 255 : k;
    if (e_ctrl[vk_pkg::F_INV]) k = 255 - k;
    k = (k * e_op + 127) / 255;
    bgt = (p[6] * (255 - k) + 127) / 255;
    if (e_ctrl[vk_pkg::F_SHOW]) y = k;
    else if (e_ctrl[vk_pkg::F_SHP]) y = ((e_ctrl[vk_pkg::F_CORE] && k == 0) ? 0 : p[3]) + bgt;
    else y = (p[3] * k + 127) / 255 + bgt;
    y = (y > 255) ? 255 : y;
    return '{care, e_ctrl[vk_pkg::F_SHOW], 8'(y), 8'(k)};
  endfunction : note_of
  always @(posedge sys_clk_in) begin
    if (pv === 1'b1) begin
      notes.push_back(note_of(px, idx < 11));
      idx = idx + 1;
    end else idx = 0;
  end
  always @(posedge sys_clk_in) begin
    if (vo === 1'b1) begin
      if (notes.size() == 0) check(32'h1, 32'h0, "output without sample");
      else begin
        mon_n = notes.pop_front();
        if (mon_n.care) begin
          check(ko, mon_n.k, "key");
          check(oy, mon_n.y, "luma");
          if (mon_n.show) check({ocb, ocr}, 16'h8080, "show chroma");
        end
      end
    end
  end
  task automatic bus(input logic w, input logic [3:0] a, input logic [31:0] d,
                     output logic [31:0] q);
    int n;
    n = 0;
    @(posedge sys_clk_in);
    wr <= w;
    rd <= !w;
    adr <= a;
    wdat <= d;
    do begin
      @(posedge sys_clk_in);
      n++;
    end while (wait_rq !== 1'b0 && n < 50);
    q = rdat;
    if (n >= 50) check(32'h1, 32'h0, "bus timeout");
    wr <= 1'b0;
    rd <= 1'b0;
  endtask : bus
  task automatic wreg(input logic [3:0] a, input logic [31:0] d);
    logic [31:0] q;
    bus(1'b1, a, d, q);
  endtask : wreg
  task automatic rchk(input logic [3:0] a, input logic [31:0] exp);
    logic [31:0] q;
    bus(1'b0, a, 32'h0, q);
    check(q, exp, "register read");
  endtask : rchk
  task automatic fstart;
    @(posedge sys_clk_in);
    fs <= 1'b1;
    @(posedge sys_clk_in);
    fs <= 1'b0;
  endtask : fstart
  task automatic burst;
    @(posedge sys_clk_in);
    en <= 1'b1;
    repeat (15) @(posedge sys_clk_in);
    en <= 1'b0;
    repeat (6) @(posedge sys_clk_in);
  endtask : burst
  task automatic run(input string name, input logic [9:0] ctrl, input logic [31:0] shape);
    wreg(vk_pkg::R_CTRL, {22'h0, ctrl});
    wreg(vk_pkg::R_SHAPE, shape);
    fstart();
    e_ctrl = ctrl;
    e_op = shape[7:0];
    burst();
    $display("test %s done", name);
  endtask : run
  initial begin
    repeat (4) notes.push_back('0);
    repeat (8) @(posedge sys_clk_in);
    sys_rst_in <= 1'b0;
    for (int i = 0; i < 7; i++) rchk(4'(i), vk_pkg::RST_REGS[i]);
    rchk(4'hC, 32'h0000_0000);
    be <= 4'h1;
    wreg(vk_pkg::R_CTRL, 32'h0000_0220);
    be <= 4'hF;
    rchk(vk_pkg::R_CTRL, 32'h0000_0020);
    $display("test registers done");
    wreg(vk_pkg::R_CLIP, 32'h0000_0080);
    run("fixed linear", 10'h000, 32'h0000_03FF);
    wreg(vk_pkg::R_SHAPE, 32'h0000_0380);
    burst();
    fstart();
    e_op = 8'h80;
    burst();
    $display("test opacity done");
    run("invert", 10'h010, 32'h0000_03FF);
    run("opacity zero", 10'h000, 32'h0000_0300);
    run("pattern invert", 10'h013, 32'h0000_03FF);
    run("show key", 10'h020, 32'h0000_03C0);
    wreg(vk_pkg::R_CLIP, vk_pkg::RST_CLIP);
    wreg(vk_pkg::R_TRIM, 32'h0000_8000);
    e_gain = 68;
    run("adjust trim", 10'h008, 32'h0000_03FF);
    e_gain = 100;
    wreg(vk_pkg::R_TRIM, 32'h0000_0000);
    run("pattern", 10'h003, 32'h0000_03FF);
    run("split", 10'h004, 32'h0000_03FF);
    wreg(vk_pkg::R_CLIP, 32'h0000_0080);
    e_gain = 0;
    run("split hard", 10'h004, 32'h0000_03FF);
    e_gain = 100;
    mask <= 8'h00;
    run("coring", 10'h140, 32'h0000_03FF);
    end_sim();
  end
  initial begin
    #100000;
    fails++;
    $display("ERROR %0t watchdog expired", $time);
    end_sim();
  end
endmodule : vk_keyer_tb_top
